// File: core/adc_serial_device.sv
// converter end of the serial link: frame tracking, result shifter, pin capture
//
// Operation
// - full frame is sixteen clocks, two megasamples
// - short frame lifts throughput per resolution
// - result width set by resolution parameter
// - select low routes channel 0, high 1
// - host moves select half clock after fall
// - power-down pin taken at select rising edge
// - select low marks an active frame
// - short frame is resolution plus 1.5 clocks
`timescale 1ns/1ps
`default_nettype none

module adc_serial_device
    import adc_link_pkg::*;
#(
    parameter int RES = RESOLUTION
) (
    // clock and reset
    input  wire logic           clk_sys,
    input  wire logic           reset,
    // serial link
    adc_link_if.device          link,
    // converter core side
    input  wire logic [RES-1:0] conv_word,
    output logic                sample_start,
    output logic                channel_route,
    output logic                auto_sleep_en,
    // frame status
    output logic                frame_active,
    output logic                frame_done,
    output logic                frame_short,
    output logic                frame_aborted,
    output logic [CLK_CNT_W-1:0] frame_clocks
);

    // ------------------------------------------------------------------
    // edge detection on the link inputs
    // ------------------------------------------------------------------
    logic cs_prev_q;
    logic cs_prev_d;
    logic sclk_prev_q;
    logic sclk_prev_d;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;

    always_comb begin
        cs_prev_d   = link.cs_n;
        sclk_prev_d = link.sclk;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cs_prev_q   <= CS_IDLE;
            sclk_prev_q <= SCLK_IDLE;
        end else begin
            cs_prev_q   <= cs_prev_d;
            sclk_prev_q <= sclk_prev_d;
        end
    end

    // select is active low: only its low periods open a frame
    assign cs_fall   = cs_prev_q & ~link.cs_n;
    assign cs_rise   = ~cs_prev_q & link.cs_n;
    assign sclk_rise = ~sclk_prev_q & link.sclk;
    assign sclk_fall = sclk_prev_q & ~link.sclk;

    // ------------------------------------------------------------------
    // frame state, result shifter and status
    // ------------------------------------------------------------------
    dev_state_t             state_q;
    dev_state_t             state_d;
    logic [RES-1:0]         shift_q;
    logic [RES-1:0]         shift_d;
    logic [BIT_CNT_W-1:0]   bit_idx_q;
    logic [BIT_CNT_W-1:0]   bit_idx_d;
    logic [CLK_CNT_W-1:0]   rises_q;
    logic [CLK_CNT_W-1:0]   rises_d;
    logic                   sdo_q;
    logic                   sdo_d;
    logic                   start_q;
    logic                   start_d;
    logic                   route_q;
    logic                   route_d;
    logic                   sleep_q;
    logic                   sleep_d;
    logic                   active_q;
    logic                   active_d;
    logic                   done_q;
    logic                   done_d;
    logic                   short_q;
    logic                   short_d;
    logic                   abort_q;
    logic                   abort_d;
    logic [CLK_CNT_W-1:0]   clocks_q;
    logic [CLK_CNT_W-1:0]   clocks_d;

    localparam logic [BIT_CNT_W-1:0] LAST_BIT   = BIT_CNT_W'(RES - 1);
    localparam logic [BIT_CNT_W-1:0] BITS_DONE  = BIT_CNT_W'(RES);
    localparam logic [CLK_CNT_W-1:0] FULL_CLKS  = CLK_CNT_W'(FULL_FRAME_CLOCKS);
    localparam logic [CLK_CNT_W-1:0] RES_CLKS   = CLK_CNT_W'(RES);
    localparam logic [CLK_CNT_W-1:0] CLK_MAX    = {CLK_CNT_W{1'b1}};

    always_comb begin
        state_d   = state_q;
        shift_d   = shift_q;
        bit_idx_d = bit_idx_q;
        rises_d   = rises_q;
        sdo_d     = sdo_q;
        start_d   = 1'b0;
        sleep_d   = sleep_q;
        active_d  = active_q;
        done_d    = 1'b0;
        short_d   = short_q;
        abort_d   = abort_q;
        clocks_d  = clocks_q;
        // multiplexer follows the select pin one clock later, in every state
        route_d   = link.input_channel_pick;

        case (state_q)
            D_IDLE: begin
                sdo_d = SDO_IDLE;
                if (cs_fall) begin
                    state_d   = D_FRAME;
                    shift_d   = conv_word;
                    sdo_d     = conv_word[RES-1];
                    bit_idx_d = '0;
                    rises_d   = '0;
                    start_d   = 1'b1;
                    active_d  = 1'b1;
                end
            end
            D_FRAME: begin
                if (sclk_rise && rises_q != CLK_MAX) begin
                    rises_d = rises_q + 1'b1;
                end
                // next bit goes out on each falling serial clock edge
                if (sclk_fall) begin
                    if (bit_idx_q < LAST_BIT) begin
                        shift_d   = {shift_q[RES-2:0], 1'b0};
                        sdo_d     = shift_q[RES-2];
                        bit_idx_d = bit_idx_q + 1'b1;
                    end else begin
                        sdo_d     = SDO_IDLE;
                        bit_idx_d = BITS_DONE;
                    end
                end
                if (cs_rise) begin
                    state_d  = D_IDLE;
                    sdo_d    = SDO_IDLE;
                    active_d = 1'b0;
                    done_d   = 1'b1;
                    // power-down request is caught only at this edge
                    sleep_d  = link.auto_sleep_request;
                    // fewer than sixteen clocks counts as a short frame
                    short_d  = (rises_q < FULL_CLKS);
                    abort_d  = (rises_q < RES_CLKS);
                    clocks_d = rises_q;
                end
            end
            default: begin
                state_d  = D_IDLE;
                sdo_d    = SDO_IDLE;
                active_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q   <= D_IDLE;
            shift_q   <= '0;
            bit_idx_q <= '0;
            rises_q   <= '0;
            sdo_q     <= SDO_IDLE;
            start_q   <= 1'b0;
            route_q   <= CHANNEL_RESET;
            sleep_q   <= SLEEP_RESET;
            active_q  <= 1'b0;
            done_q    <= 1'b0;
            short_q   <= 1'b0;
            abort_q   <= 1'b0;
            clocks_q  <= '0;
        end else begin
            state_q   <= state_d;
            shift_q   <= shift_d;
            bit_idx_q <= bit_idx_d;
            rises_q   <= rises_d;
            sdo_q     <= sdo_d;
            start_q   <= start_d;
            route_q   <= route_d;
            sleep_q   <= sleep_d;
            active_q  <= active_d;
            done_q    <= done_d;
            short_q   <= short_d;
            abort_q   <= abort_d;
            clocks_q  <= clocks_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign link.sdo      = sdo_q;
    assign sample_start  = start_q;
    assign channel_route = route_q;
    assign auto_sleep_en = sleep_q;
    assign frame_active  = active_q;
    assign frame_done    = done_q;
    assign frame_short   = short_q;
    assign frame_aborted = abort_q;
    assign frame_clocks  = clocks_q;

endmodule

`default_nettype wire

// File: shared/adc_link_pkg.sv
// constants and types shared by both ends of the converter serial link
package adc_link_pkg;

    // ------------------------------------------------------------------
    // resolution and frame shape
    // ------------------------------------------------------------------
    localparam int RESOLUTION          = 12;
    localparam int FULL_FRAME_CLOCKS   = 16;
    // a short frame holds the select low for resolution + 1.5 clocks
    localparam int SHORT_EXTRA_HALVES  = 3;
    localparam int FULL_FRAME_HALVES   = 2 * FULL_FRAME_CLOCKS;
    localparam int CLK_CNT_W           = 6;
    localparam int HALF_CNT_W          = 6;
    localparam int BIT_CNT_W           = 5;

    // ------------------------------------------------------------------
    // throughput figures in kilosamples per second
    // ------------------------------------------------------------------
    localparam int FULL_FRAME_KSPS     = 2000;
    localparam int SHORT_KSPS_12       = 2100;
    localparam int SHORT_KSPS_10       = 2570;
    localparam int SHORT_KSPS_8        = 3000;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_SYS_PERIOD_NS   = 20;
    // least half period of the serial clock; must come to 2 cycles or more
    localparam int SCLK_HALF_NS        = 40;
    localparam int SCLK_HALF_CYC       =
        (SCLK_HALF_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
    localparam int DIV_CNT_W           = 4;

    // ------------------------------------------------------------------
    // reset and idle levels of the link
    // ------------------------------------------------------------------
    localparam logic CS_IDLE           = 1'b1;
    localparam logic SCLK_IDLE         = 1'b0;
    localparam logic SDO_IDLE          = 1'b0;
    localparam logic CHANNEL_RESET     = 1'b0;
    localparam logic SLEEP_RESET       = 1'b0;

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        D_IDLE  = 2'b01,
        D_FRAME = 2'b10
    } dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_RUN  = 3'b010,
        H_GAP  = 3'b100
    } host_state_t;

endpackage

// File: shared/adc_link_if.sv
// serial link between the converter frame logic and its host controller
`timescale 1ns/1ps
`default_nettype none

interface adc_link_if;
    logic cs_n;
    logic sclk;
    logic sdo;
    logic input_channel_pick;
    logic auto_sleep_request;

    modport device (
        input  cs_n,
        input  sclk,
        input  input_channel_pick,
        input  auto_sleep_request,
        output sdo
    );

    modport host (
        output cs_n,
        output sclk,
        output input_channel_pick,
        output auto_sleep_request,
        input  sdo
    );
endinterface

`default_nettype wire

// File: core/adc_serial_host.sv
// host end of the serial link: frame generator and result capture
`timescale 1ns/1ps
`default_nettype none

module adc_serial_host
    import adc_link_pkg::*;
#(
    parameter int RES = RESOLUTION
) (
    // clock and reset
    input  wire logic           clk_sys,
    input  wire logic           reset,
    // serial link
    adc_link_if.host            link,
    // user request
    input  wire logic           start,
    input  wire logic           channel_req,
    input  wire logic           sleep_req,
    input  wire logic           short_req,
    // user answer
    output logic                busy,
    output logic                result_valid,
    output logic [RES-1:0]      result_word
);

    // ------------------------------------------------------------------
    // frame generator
    // ------------------------------------------------------------------
    localparam logic [DIV_CNT_W-1:0]  DIV_LAST   = DIV_CNT_W'(SCLK_HALF_CYC - 1);
    localparam logic [HALF_CNT_W-1:0] FULL_END   = HALF_CNT_W'(FULL_FRAME_HALVES);
    localparam logic [HALF_CNT_W-1:0] SHORT_END  =
        HALF_CNT_W'(2 * RES + SHORT_EXTRA_HALVES);
    localparam logic [HALF_CNT_W-1:0] FIRST_RISE = HALF_CNT_W'(1);
    localparam logic [BIT_CNT_W-1:0]  BITS_ALL   = BIT_CNT_W'(RES);

    host_state_t            state_q;
    host_state_t            state_d;
    logic [DIV_CNT_W-1:0]   div_q;
    logic [DIV_CNT_W-1:0]   div_d;
    logic [HALF_CNT_W-1:0]  half_q;
    logic [HALF_CNT_W-1:0]  half_d;
    logic [HALF_CNT_W-1:0]  half_nx;
    logic [HALF_CNT_W-1:0]  end_q;
    logic [HALF_CNT_W-1:0]  end_d;
    logic [BIT_CNT_W-1:0]   bits_q;
    logic [BIT_CNT_W-1:0]   bits_d;
    logic [RES-1:0]         shift_q;
    logic [RES-1:0]         shift_d;
    logic                   cs_n_q;
    logic                   cs_n_d;
    logic                   sclk_q;
    logic                   sclk_d;
    logic                   chan_req_q;
    logic                   chan_req_d;
    logic                   chan_q;
    logic                   chan_d;
    logic                   sleep_q;
    logic                   sleep_d;
    logic                   busy_q;
    logic                   busy_d;
    logic                   valid_q;
    logic                   valid_d;
    logic [RES-1:0]         result_q;
    logic [RES-1:0]         result_d;

    always_comb begin
        state_d    = state_q;
        div_d      = div_q;
        half_d     = half_q;
        end_d      = end_q;
        bits_d     = bits_q;
        shift_d    = shift_q;
        cs_n_d     = cs_n_q;
        sclk_d     = sclk_q;
        chan_req_d = chan_req_q;
        chan_d     = chan_q;
        sleep_d    = sleep_q;
        busy_d     = busy_q;
        valid_d    = 1'b0;
        result_d   = result_q;
        half_nx    = half_q + 1'b1;

        case (state_q)
            H_IDLE: begin
                if (start) begin
                    state_d    = H_RUN;
                    cs_n_d     = 1'b0;
                    sclk_d     = SCLK_IDLE;
                    div_d      = '0;
                    half_d     = '0;
                    bits_d     = '0;
                    end_d      = short_req ? SHORT_END : FULL_END;
                    chan_req_d = channel_req;
                    sleep_d    = sleep_req;
                    busy_d     = 1'b1;
                end
            end
            H_RUN: begin
                div_d = div_q + 1'b1;
                if (div_q == DIV_LAST) begin
                    div_d  = '0;
                    half_d = half_nx;
                    if (half_nx == end_q) begin
                        // close the frame; sleep pin is held steady across this edge
                        cs_n_d  = CS_IDLE;
                        sclk_d  = SCLK_IDLE;
                        state_d = H_GAP;
                    end else begin
                        sclk_d = ~sclk_q;
                        if (!sclk_q && bits_q < BITS_ALL) begin
                            shift_d = {shift_q[RES-2:0], link.sdo};
                            bits_d  = bits_q + 1'b1;
                        end
                        // channel moves half a clock after the select falls
                        if (half_nx == FIRST_RISE) begin
                            chan_d = chan_req_q;
                        end
                    end
                end
            end
            H_GAP: begin
                div_d = div_q + 1'b1;
                if (div_q == DIV_LAST) begin
                    div_d    = '0;
                    state_d  = H_IDLE;
                    busy_d   = 1'b0;
                    valid_d  = 1'b1;
                    result_d = shift_q;
                end
            end
            default: begin
                state_d = H_IDLE;
                cs_n_d  = CS_IDLE;
                sclk_d  = SCLK_IDLE;
                busy_d  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q    <= H_IDLE;
            div_q      <= '0;
            half_q     <= '0;
            end_q      <= FULL_END;
            bits_q     <= '0;
            shift_q    <= '0;
            cs_n_q     <= CS_IDLE;
            sclk_q     <= SCLK_IDLE;
            chan_req_q <= CHANNEL_RESET;
            chan_q     <= CHANNEL_RESET;
            sleep_q    <= SLEEP_RESET;
            busy_q     <= 1'b0;
            valid_q    <= 1'b0;
            result_q   <= '0;
        end else begin
            state_q    <= state_d;
            div_q      <= div_d;
            half_q     <= half_d;
            end_q      <= end_d;
            bits_q     <= bits_d;
            shift_q    <= shift_d;
            cs_n_q     <= cs_n_d;
            sclk_q     <= sclk_d;
            chan_req_q <= chan_req_d;
            chan_q     <= chan_d;
            sleep_q    <= sleep_d;
            busy_q     <= busy_d;
            valid_q    <= valid_d;
            result_q   <= result_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign link.cs_n               = cs_n_q;
    assign link.sclk               = sclk_q;
    assign link.input_channel_pick = chan_q;
    assign link.auto_sleep_request = sleep_q;
    assign busy                    = busy_q;
    assign result_valid            = valid_q;
    assign result_word             = result_q;

endmodule

`default_nettype wire

// File: verification/adc_link_asserts.sv
// interface-level checks of the converter serial link
`timescale 1ns/1ps
`default_nettype none

module adc_link_asserts
    import adc_link_pkg::*;
#(
    parameter int RES = RESOLUTION
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // serial link
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic sdo,
    input  wire logic input_channel_pick,
    input  wire logic auto_sleep_request
);
    localparam int FULL_LOW  = FULL_FRAME_HALVES * SCLK_HALF_CYC;
    localparam int SHORT_LOW = (2 * RES + SHORT_EXTRA_HALVES) * SCLK_HALF_CYC;

    // ------------------------------------------------------------------
    // frame length and sclk rise counters
    // ------------------------------------------------------------------
    logic [6:0] low_q;
    logic [6:0] low_d;
    logic [5:0] rise_q;
    logic [5:0] rise_d;
    logic       sclk_q;

    always_comb begin
        low_d  = cs_n ? 7'h00 : low_q + 7'h01;
        rise_d = cs_n ? 6'h00 : rise_q + {5'h00, sclk & ~sclk_q};
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            low_q  <= 7'h00;
            rise_q <= 6'h00;
            sclk_q <= SCLK_IDLE;
        end else begin
            low_q  <= low_d;
            rise_q <= rise_d;
            sclk_q <= sclk;
        end
    end

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("serial clock high outside a frame");
    a_sdo_idle: assert property (cs_n [*3] |-> !sdo)
        else $error("data output not idle outside a frame");
    a_frame_length: assert property ($rose(cs_n) |->
        low_q == FULL_LOW || low_q == SHORT_LOW)
        else $error("select low for a wrong number of cycles");
    a_rise_count: assert property ($rose(cs_n) |->
        rise_q == (low_q == FULL_LOW ? FULL_FRAME_CLOCKS : RES + 1))
        else $error("wrong count of serial clock rises in frame");
    a_sleep_steady: assert property ($rose(cs_n) |-> $stable(auto_sleep_request))
        else $error("power-down request moved at the select rising edge");
    a_first_edge: assert property ($fell(cs_n) |-> !sclk [*2] ##1 sclk)
        else $error("first rise not half a clock after select fall");
    a_sclk_period: assert property ($rose(sclk) |-> sclk [*2] ##1 !sclk)
        else $error("serial clock high time wrong");
    a_pick_window: assert property ($changed(input_channel_pick) |->
        $rose(sclk) && $past(cs_n, 3) && !$past(cs_n, 2))
        else $error("channel pick moved outside its window");
    a_close_gap: assert property ($rose(cs_n) |-> cs_n [*3])
        else $error("select high too short between frames");
endmodule

`default_nettype wire

// File: verification/testbench.sv
// self-checking bench joining host and converter ends of the serial link
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %0h expected %0h", $time, (a), (b)); end end

module testbench
    import adc_link_pkg::*;
;
    logic                  clk_sys;
    logic                  reset;
    logic [RESOLUTION-1:0] conv_word;
    logic                  start;
    logic                  channel_req;
    logic                  sleep_req;
    logic                  short_req;
    logic                  busy;
    logic                  result_valid;
    logic [RESOLUTION-1:0] result_word;
    logic                  sample_start;
    logic                  channel_route;
    logic                  auto_sleep_en;
    logic                  frame_active;
    logic                  frame_done;
    logic                  frame_short;
    logic                  frame_aborted;
    logic [CLK_CNT_W-1:0]  frame_clocks;
    int                    n_mismatch;
    int                    samples_checked;

    adc_link_if lnk ();

    adc_serial_host adc_serial_host_i (
        .clk_sys(clk_sys), .reset(reset), .link(lnk), .start(start),
        .channel_req(channel_req), .sleep_req(sleep_req), .short_req(short_req),
        .busy(busy), .result_valid(result_valid), .result_word(result_word)
    );

    adc_serial_device adc_serial_device_i (
        .clk_sys(clk_sys), .reset(reset), .link(lnk), .conv_word(conv_word),
        .sample_start(sample_start), .channel_route(channel_route),
        .auto_sleep_en(auto_sleep_en), .frame_active(frame_active),
        .frame_done(frame_done), .frame_short(frame_short),
        .frame_aborted(frame_aborted), .frame_clocks(frame_clocks)
    );

    adc_link_asserts #(.RES(RESOLUTION)) adc_link_asserts_i (
        .clk_sys(clk_sys), .reset(reset), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
        .sdo(lnk.sdo), .input_channel_pick(lnk.input_channel_pick),
        .auto_sleep_request(lnk.auto_sleep_request)
    );

    // ------------------------------------------------------------------
    // closing and shared frame task
    // ------------------------------------------------------------------
    task automatic conclude;
        $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // runs one frame, watching the wire, then judges both ends
    task automatic do_frame(input logic [RESOLUTION-1:0] w, input logic ch,
                            input logic slp, input logic shrt, input logic poke);
        logic [RESOLUTION-1:0] seen;
        logic [5:0]            rises;
        logic [6:0]            low_len;
        logic                  sclk_p;
        int                    cyc;
        int                    starts;
        int                    dones;
        int                    halves;
        halves  = shrt ? 2 * RESOLUTION + SHORT_EXTRA_HALVES : FULL_FRAME_HALVES;
        seen    = '0;
        rises   = 6'h00;
        low_len = 7'h00;
        sclk_p  = SCLK_IDLE;
        cyc     = -1;
        starts  = 0;
        dones   = 0;
        @(posedge clk_sys);
        #1;
        conv_word   = w;
        channel_req = ch;
        sleep_req   = slp;
        short_req   = shrt;
        start       = 1'b1;
        while (result_valid !== 1'b1 && cyc < 200) begin
            @(posedge clk_sys);
            #1;
            cyc++;
            start = (cyc == 10) ? poke : 1'b0;
            if (sclk_p === 1'b0 && lnk.sclk === 1'b1) begin
                if (rises < RESOLUTION) seen = {seen[RESOLUTION-2:0], lnk.sdo};
                rises++;
            end
            sclk_p  = lnk.sclk;
            low_len += {6'h00, lnk.cs_n === 1'b0};
            starts  += int'(sample_start === 1'b1);
            dones   += int'(frame_done === 1'b1);
            if (cyc == 20) begin
                `CHK(frame_active, 1'b1)
                `CHK(busy, 1'b1)
                `CHK(channel_route, ch)
                `CHK(lnk.input_channel_pick, ch)
            end
        end
        `CHK(cyc, (halves + 1) * SCLK_HALF_CYC)
        `CHK(low_len, 7'(halves * SCLK_HALF_CYC))
        `CHK(rises, 6'(shrt ? RESOLUTION + 1 : FULL_FRAME_CLOCKS))
        `CHK(seen, w)
        `CHK(result_word, w)
        repeat (3) begin
            @(posedge clk_sys);
            #1;
            starts += int'(sample_start === 1'b1);
            dones  += int'(frame_done === 1'b1);
        end
        `CHK(starts, 1)
        `CHK(dones, 1)
        `CHK(busy, 1'b0)
        `CHK(frame_active, 1'b0)
        `CHK(auto_sleep_en, slp)
        `CHK(frame_short, shrt)
        `CHK(frame_aborted, 1'b0)
        `CHK(frame_clocks, 6'(shrt ? RESOLUTION + 1 : FULL_FRAME_CLOCKS))
        `CHK(lnk.sdo, SDO_IDLE)
        `CHK(lnk.cs_n, CS_IDLE)
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic test_full_frame;
        do_frame(12'ha5c, 1'b0, 1'b1, 1'b0, 1'b0);
    endtask

    task automatic test_short_frame;
        do_frame(12'h3c9, 1'b1, 1'b0, 1'b1, 1'b0);
    endtask

    // a second start during a frame must be ignored
    task automatic test_refused_start;
        do_frame(12'h5a3, 1'b1, 1'b1, 1'b0, 1'b1);
    endtask

    // boundary words back to back, alternating channel and sleep, two full frames then two short
    task automatic test_edge_words;
        logic [RESOLUTION-1:0] words [4];
        words = '{12'h800, 12'h001, 12'hfff, 12'h000};
        for (int i = 0; i < 4; i++) begin
            do_frame(words[i], i[0], ~i[0], i[1], 1'b0);
        end
    endtask

    // ------------------------------------------------------------------
    // clock, reset, sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #(CLK_SYS_PERIOD_NS / 2) clk_sys = ~clk_sys;
    end

    initial begin
        n_mismatch      = 0;
        samples_checked = 0;
        reset           = 1'b1;
        conv_word       = '0;
        start           = 1'b0;
        channel_req     = 1'b0;
        sleep_req       = 1'b0;
        short_req       = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        test_full_frame();
        test_short_frame();
        test_refused_start();
        test_edge_words();
        conclude();
    end

    initial begin
        #(CLK_SYS_PERIOD_NS * 5000);
        n_mismatch++;
        conclude();
    end
endmodule

`default_nettype wire
